// file: logic/uss_regs.vh
// Constants for the suspend-state control block.
`ifndef USS_REGS_VH
`define USS_REGS_VH
`define USS_NPINS 16
`define USS_SUSP_RST 1'b1
`define USS_CFG_RST 1'b0
`define USS_ST_RESET 3'h1
`define USS_ST_SUSP 3'h2
`define USS_ST_AWAKE 3'h4
`define USS_SUSP_N_RST 1'b0
`define USS_DRV_RST 1'b0
`define USS_LO 1'b0
`define USS_HI 1'b1
`endif

// file: logic/uss_suspend_ctrl.v
// Suspend-state control with complementary suspend indicators and suspend pin levels.
`timescale 1ns/1ns
`default_nettype none
`include "uss_regs.vh"
// How it works
// R1 - Bus suspend signaling enters the suspend state.
// R2 - Suspend entry asserts both suspend indicators.
// R3 - After reset, indicators stay asserted until configured.
// R4 - Resume, bus reset or device reset exit suspend.
// R5 - Leaving suspend by resume or bus reset deasserts both suspend indicators.
// R6 - Indicators undriven while device reset is held.
// R7 - Suspended pins take configured level and mode.
// R8 - Function controller carries data and commands.
// R9 - One indicator active high, one active low.
// R10 - Both indicators come from one flag.

module uss_suspend_ctrl #(
  parameter NPINS = `USS_NPINS
) (
  input wire clk_sys,
  input wire nrst,

  // Bus conditions seen by the function controller.
  input wire bus_suspend_det,
  input wire bus_resume_det,
  input wire dev_resume_gen,
  input wire bus_reset_det,
  input wire configured,

  // Suspend pin setup from nonvolatile storage, static while running.
  input wire [NPINS-1:0] cfg_susp_sel,
  input wire [NPINS-1:0] cfg_susp_level,
  input wire [NPINS-1:0] cfg_susp_pushpull,

  // Functional pin drive from the serial and general-purpose logic.
  input wire [NPINS-1:0] func_pin_out,
  input wire [NPINS-1:0] func_pin_oe,

  // Suspend indicators with their enables, and the registered pins.
  output wire suspend_out,
  output wire suspend_oe,
  output wire suspend_n_out,
  output wire suspend_n_oe,
  output wire suspended,
  output reg [NPINS-1:0] pin_out_ff,
  output reg [NPINS-1:0] pin_oe_ff
);

  // One-hot state codes.
  localparam [2:0] ST_RESET = `USS_ST_RESET;
  localparam [2:0] ST_SUSP = `USS_ST_SUSP;
  localparam [2:0] ST_AWAKE = `USS_ST_AWAKE;

  // Decoded bus conditions.
  wire wake_bus;
  wire wake_dev;
  wire wake_reset;
  wire susp_req;
  wire cfg_done;

  // State, indicator and drive registers with their next values.
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg susp_ff;
  reg nxt_susp;
  reg susp_n_ff;
  reg nxt_susp_n;
  reg drive_ff;
  reg nxt_drive;
  reg pin_hold;

  // Per-pin suspend setting and next drive values.
  wire [NPINS-1:0] susp_sel_act;
  wire [NPINS-1:0] susp_pin_out;
  wire [NPINS-1:0] susp_pin_oe;
  wire [NPINS-1:0] nxt_pin_out;
  wire [NPINS-1:0] nxt_pin_oe;

  genvar gi;

  assign wake_bus = bus_resume_det; // [R4]
  assign wake_dev = dev_resume_gen; // [R4]
  assign wake_reset = bus_reset_det; // [R4]
  // A bus reset in the same cycle wins over suspend signaling.
  assign susp_req = bus_suspend_det & ~bus_reset_det; // [R1]
  assign cfg_done = configured; // [R3]

  // State walk: reset hold until configured, then awake and suspended in turn.
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RESET: begin
        if (cfg_done) begin
          nxt_state = ST_AWAKE; // [R3]
        end
      end
      ST_SUSP: begin
        if (wake_bus) begin
          nxt_state = ST_AWAKE; // [R4]
        end else if (wake_dev) begin
          nxt_state = ST_AWAKE; // [R4]
        end else if (wake_reset) begin
          nxt_state = ST_AWAKE; // [R4]
        end
      end
      ST_AWAKE: begin
        if (susp_req) begin
          nxt_state = ST_SUSP; // [R1]
        end
      end
      default: begin
        nxt_state = ST_RESET;
      end
    endcase
  end

  // Indicator and pin decode of the state being entered.
  always @* begin
    nxt_susp = `USS_SUSP_RST;
    pin_hold = `USS_LO;
    case (nxt_state)
      ST_RESET: begin
        nxt_susp = `USS_HI; // [R3]
        pin_hold = `USS_LO;
      end
      ST_SUSP: begin
        nxt_susp = `USS_HI; // [R2]
        pin_hold = `USS_HI; // [R7]
      end
      ST_AWAKE: begin
        nxt_susp = `USS_LO; // [R5]
        pin_hold = `USS_LO;
      end
      default: begin
        nxt_susp = `USS_SUSP_RST;
        pin_hold = `USS_LO;
      end
    endcase
    nxt_susp_n = ~nxt_susp; // [R9] [R10]
    nxt_drive = `USS_HI; // [R6]
  end

  // A device reset always returns to the reset hold.
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_RESET; // [R3] [R4]
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Both indicators come from one decoded flag, so they never agree.
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      susp_ff <= `USS_SUSP_RST;
    end else begin
      susp_ff <= nxt_susp; // [R10]
    end
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      susp_n_ff <= `USS_SUSP_N_RST;
    end else begin
      susp_n_ff <= nxt_susp_n; // [R10]
    end
  end

  // The drive enable rises at the first edge after reset is released.
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      drive_ff <= `USS_DRV_RST; // [R6]
    end else begin
      drive_ff <= nxt_drive;
    end
  end

  assign suspended = susp_ff;
  assign suspend_out = susp_ff; // [R2] [R9]
  assign suspend_n_out = susp_n_ff; // [R2] [R9]
  // Reset also drops the enables at once, without waiting for a clock edge.
  assign suspend_oe = drive_ff & nrst; // [R6]
  assign suspend_n_oe = drive_ff & nrst; // [R6]

  // Per-pin choice between functional drive and the suspend setting.
  generate
    for (gi = 0; gi < NPINS; gi = gi + 1) begin : g_pin
      assign susp_sel_act[gi] = pin_hold & cfg_susp_sel[gi]; // [R7]
      assign susp_pin_out[gi] = cfg_susp_level[gi]; // [R7]
      // Open-drain high releases the pin so the pull-up sets the level.
      assign susp_pin_oe[gi] = cfg_susp_pushpull[gi] | ~cfg_susp_level[gi]; // [R7]
      assign nxt_pin_out[gi] = susp_sel_act[gi] ?
        susp_pin_out[gi] :
        func_pin_out[gi]; // [R8]
      assign nxt_pin_oe[gi] = susp_sel_act[gi] ?
        susp_pin_oe[gi] :
        func_pin_oe[gi]; // [R8]
    end
  endgenerate

  // Pin levels are registered so they change in step with the indicators.
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_out_ff <= {NPINS{`USS_CFG_RST}};
    end else begin
      pin_out_ff <= nxt_pin_out;
    end
  end

  // Pin enables follow the same choice as the pin levels.
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_oe_ff <= {NPINS{`USS_CFG_RST}};
    end else begin
      pin_oe_ff <= nxt_pin_oe;
    end
  end
endmodule // uss_suspend_ctrl
`default_nettype wire

// file: verif/uss_suspend_ctrl_chk.sv
// Checker for the suspend indicators.
`timescale 1ns/1ns
`default_nettype none
module uss_chk(input wire clk_sys,nrst,bus_suspend_det,bus_resume_det,dev_resume_gen,bus_reset_det,configured,
  suspend_out,suspend_n_out,suspend_oe,suspend_n_oe,suspended,
  input wire [15:0] cfg_susp_sel,cfg_susp_level,cfg_susp_pushpull,pin_oe_ff);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  compl_ind_a: assert property (suspend_n_out!=suspend_out) else $error("e");
  ind_driven_a: assert property ($past(nrst)|->suspend_oe&&suspend_n_oe) else $error("e");
  susp_enter_a: assert property (!suspend_out&&bus_suspend_det&&!bus_reset_det|=>suspend_out) else $error("e");
  exit_cause_a: assert property ($fell(suspend_out)|->$past(bus_resume_det||dev_resume_gen||bus_reset_det||configured))
    else $error("e");
  susp_hold_a: assert property (suspend_out&&!(configured||bus_resume_det||dev_resume_gen||bus_reset_det)|=>suspend_out)
    else $error("e");
  pin_susp_a: assert property ($rose(suspended)|->(pin_oe_ff&cfg_susp_sel)==(cfg_susp_sel&(cfg_susp_pushpull|~cfg_susp_level)))
    else $error("e");
endmodule // uss_chk
bind uss_suspend_ctrl uss_chk chk_i(.*);
`default_nettype wire

// file: verif/uss_host.sv
// Host-side model that signals bus conditions.
`timescale 1ns/1ns
`default_nettype none
module uss_host(input wire clk_sys,output wire bus_suspend_det,bus_resume_det,dev_resume_gen,bus_reset_det,configured);
  logic [4:0] ev_ff=5'h00;
  assign {configured,bus_reset_det,dev_resume_gen,bus_resume_det,bus_suspend_det}=ev_ff;
  // Each condition stands alone for one edge, as the host signals it.
  task automatic send(input int k);
    @(posedge clk_sys) ev_ff<=5'h01<<k;
    @(posedge clk_sys) ev_ff<=5'h00;
    #1;
  endtask
endmodule // uss_host
`default_nettype wire

// file: verif/test_usb_suspend_state_control.sv
// Testbench for suspend-state control.
`timescale 1ns/1ns
`default_nettype none
module test_usb_suspend_state_control;
  logic clk_sys=0,nrst=0,bus_suspend_det,bus_resume_det,dev_resume_gen,bus_reset_det,configured;
  logic suspend_out,suspend_oe,suspend_n_out,suspend_n_oe,suspended;
  logic [15:0] cfg_susp_sel=16'h00ff,cfg_susp_level=16'h0f0f,cfg_susp_pushpull=16'h3333;
  logic [15:0] func_pin_out=16'ha5a5,func_pin_oe=16'hffff,pin_out_ff,pin_oe_ff,oe_x;
  int err_total=0,comparisons=0,cyc=0;
  uss_suspend_ctrl dut(.*);
  uss_host host(.*);
  initial forever #50 clk_sys=~clk_sys;
  always @(posedge clk_sys) if (++cyc==3000) begin err_total++; final_report; end
  task chk(input logic [31:0] s,e);
    comparisons++;
    if (s!==e) begin err_total++; $display("Error %0t %h %h",$time,s,e); end
  endtask
  task final_report;
    if (err_total==0&&comparisons>0) $display("Simulation passed"); else $display("Simulation failed");
    $finish;
  endtask
  // Reset: indicators undriven, then asserted until configured, suspend refused.
  task t_reset;
    @(posedge clk_sys) nrst<=0;
    repeat(20) @(posedge clk_sys);
    #1;
    chk({suspend_out,suspend_n_out,suspend_oe,suspend_n_oe,pin_oe_ff},{4'h8,16'h0000});
    @(posedge clk_sys) nrst<=1;
    host.send(0);
    chk({suspended,suspend_out,suspend_n_out,suspend_oe,suspend_n_oe},5'h1b);
    host.send(4);
    chk({suspended,suspend_out,suspend_n_out,pin_out_ff},{3'h1,func_pin_out});
  endtask
  // Suspend then leave it by wake condition k.
  task t_cycle(input int k);
    host.send(0);
    chk({suspended,suspend_out,suspend_n_out},3'h6);
    oe_x=(cfg_susp_sel&(cfg_susp_pushpull|~cfg_susp_level))|(func_pin_oe&~cfg_susp_sel);
    chk(pin_oe_ff,oe_x);
    chk(pin_out_ff&oe_x,((cfg_susp_level&cfg_susp_sel)|(func_pin_out&~cfg_susp_sel))&oe_x);
    host.send(k);
    chk({suspended,suspend_out,suspend_n_out,pin_oe_ff},{3'h1,func_pin_oe});
  endtask
  initial begin
    t_reset;
    for (int k=1;k<4;k++) t_cycle(k);
    host.send(0);
    chk(suspend_out,1);
    t_reset;
    final_report;
  end
endmodule // test_usb_suspend_state_control
`default_nettype wire
